// ==== hdl/smc_spi_master.v ====
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
`include "smc_defs.vh"
module smc_spi_master (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [15:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    output wire serial_clk_o,
    output wire serial_tx_o,
    input wire serial_rx_i,
    output wire [3:0] slave_select_out_o,
    output wire char_irq_o
);
    // engine states
    localparam ST_IDLE = 2'd0;
    localparam ST_DLY = 2'd1;
    localparam ST_LEAD = 2'd2;
    localparam ST_TRAIL = 2'd3;

    // byte-lane merge of a 16-bit register write
    function [15:0] wmerge;
        input [15:0] old;
        input [31:0] dat;
        input [3:0] sel;
        begin
            wmerge = old;
            if (sel[0]) wmerge[7:0] = dat[7:0];
            if (sel[1]) wmerge[15:8] = dat[15:8];
        end
    endfunction

    // config byte of one chip select
    function [7:0] cfg_of;
        input [15:0] c1;
        input [15:0] c2;
        input [1:0] cs;
        begin
            case (cs)
                2'd0: cfg_of = c1[7:0];
                2'd1: cfg_of = c1[15:8];
                2'd2: cfg_of = c2[7:0];
                default: cfg_of = c2[15:8];
            endcase
        end
    endfunction

    // bus side
    reg wb_ack_q; // registered acknowledge
    reg [31:0] wb_dat_q; // registered read data
    reg [31:0] rd_d; // read mux
    wire acc = wb_cyc_i & wb_stb_i;
    wire wr_go = acc & wb_ack_q & wb_we_i; // write lands on ack edge
    wire rd_go = acc & wb_ack_q & ~wb_we_i; // read side effects
    wire [13:0] idx = wb_adr_i[15:2];

    // software registers
    reg [15:0] div_q; // clock_divider
    reg [15:0] ctl_q; // clock_control
    reg [15:0] cfg1_q; // device_config_one
    reg [15:0] cfg2_q; // device_config_two
    reg [15:0] cmd1_q; // command_one
    reg [15:0] cmd2_q; // command_two
    reg [31:0] tx_q; // data to send, both halves

    // engine state
    reg [1:0] state_q;
    reg [1:0] csel_q; // select held for the frame
    reg frame_act_q; // a frame holds its select active
    reg [11:0] flen_q; // characters in frame minus one
    reg [11:0] cnt_q; // characters done in this frame
    reg [4:0] len_q; // character length minus one
    reg [4:0] bit_q; // bit index within character
    reg [2:0] dly_q; // half periods of select delay left
    reg sclk_q; // serial clock pin
    reg char_done_q; // sticky, read-to-clear
    reg frame_done_q; // sticky, read-to-clear
    reg irq_q; // one-cycle completion pulse
    reg [3:0] ss_q; // select pins
    reg [3:0] ss_d; // next select pin levels
    reg rx_s1_q; // receive pin synchroniser
    reg rx_s2_q;

    wire en = ctl_q[`SMC_CTL_EN];
    wire loop = ctl_q[`SMC_CTL_LOOP];
    wire [15:0] cmd2_new = wmerge(cmd2_q, wb_dat_i, wb_sel_i);
    wire [1:0] cs_new = cmd2_new[`SMC_CMD2_CS_LO+1:`SMC_CMD2_CS_LO];
    wire [7:0] cfg_cur = cfg_of(cfg1_q, cfg2_q, csel_q);
    wire [7:0] cfg_new = cfg_of(cfg1_q, cfg2_q, cs_new);
    wire [1:0] dly_new = cfg_new[`SMC_CFG_DLY_LO+1:`SMC_CFG_DLY_LO];
    wire cpol = cfg_cur[`SMC_CFG_POL];
    wire cpha = cfg_cur[`SMC_CFG_PHA];
    wire busy = (state_q != ST_IDLE);
    wire start = wr_go & (idx == `SMC_IDX_CMD2) & wb_sel_i[0] &
                 cmd2_new[`SMC_CMD2_START] & en & ~busy;

    wire tick; // half-period strobe
    wire tx_bit;
    wire [31:0] rx_data;
    wire lead_t = (state_q == ST_LEAD) & tick;
    wire trail_t = (state_q == ST_TRAIL) & tick;
    // sample on leading edge in phase 0, trailing in phase 1
    wire smp = cpha ? trail_t : lead_t;
    // launch on trailing edge in phase 0, leading in phase 1
    wire shf = cpha ? (lead_t & (bit_q != 5'd0)) : trail_t;
    wire last_bit = (bit_q == len_q);
    wire char_end = trail_t & last_bit;
    // loopback takes the transmit bit instead of the pin
    wire rx_bit = loop ? tx_bit : rx_s2_q;

    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = wb_dat_q;
    assign serial_clk_o = sclk_q;
    assign serial_tx_o = tx_bit;
    assign slave_select_out_o = ss_q;
    assign char_irq_o = irq_q;

    // half-period ticks only while a character or delay runs
    smc_clkdiv #(
        .W(16)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(busy),
        .div_i(div_q),
        .tick_o(tick)
    );

    // shifter moves one bit out and one bit in per serial clock
    smc_shift u_shift (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(start),
        .len_i(cmd2_new[`SMC_CMD2_LEN_LO+4:`SMC_CMD2_LEN_LO]),
        .din_i(tx_q),
        .shift_i(shf),
        .sample_i(smp),
        .rx_bit_i(rx_bit),
        .tx_bit_o(tx_bit),
        .rx_data_o(rx_data)
    );

    // receive pin passes two flops
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1_q <= 1'b0;
            rx_s2_q <= 1'b0;
        end else begin
            rx_s1_q <= serial_rx_i;
            rx_s2_q <= rx_s1_q;
        end
    end

    // read data mux; data registers return received bits
    always @* begin
        rd_d = 32'h00000000;
        case (idx)
            `SMC_IDX_CLK_DIV: rd_d[15:0] = div_q;
            `SMC_IDX_CLK_CTL: rd_d[15:0] = ctl_q;
            `SMC_IDX_DEV_CFG1: rd_d[15:0] = cfg1_q;
            `SMC_IDX_DEV_CFG2: rd_d[15:0] = cfg2_q;
            `SMC_IDX_CMD1: rd_d[15:0] = cmd1_q;
            `SMC_IDX_CMD2: rd_d[15:0] = cmd2_q;
            `SMC_IDX_STAT1: begin
                rd_d[`SMC_ST_BUSY] = busy;
                rd_d[`SMC_ST_CHAR] = char_done_q;
                rd_d[`SMC_ST_FRAME] = frame_done_q;
                rd_d[`SMC_ST_ACT] = frame_act_q;
            end
            `SMC_IDX_STAT2: rd_d[11:0] = cnt_q;
            `SMC_IDX_DATA1: rd_d[15:0] = rx_data[15:0];
            `SMC_IDX_DATA2: rd_d[15:0] = rx_data[31:16];
            default: rd_d = 32'h00000000;
        endcase
    end

    // wishbone answer one cycle after the request, unmapped reads zero
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_q <= 1'b0;
            wb_dat_q <= 32'h00000000;
        end else begin
            wb_ack_q <= acc & ~wb_ack_q;
            if (acc & ~wb_ack_q) begin
                wb_dat_q <= rd_d;
            end
        end
    end

    // register writes on the acknowledge edge
    always @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= `SMC_RST_DIV;
            ctl_q <= `SMC_RST_REG;
            cfg1_q <= `SMC_RST_REG;
            cfg2_q <= `SMC_RST_REG;
            cmd1_q <= `SMC_RST_REG;
            cmd2_q <= `SMC_RST_REG;
            tx_q <= 32'h00000000;
        end else if (wr_go) begin
            case (idx)
                `SMC_IDX_CLK_DIV: div_q <= wmerge(div_q, wb_dat_i, wb_sel_i);
                `SMC_IDX_CLK_CTL: ctl_q <= wmerge(ctl_q, wb_dat_i, wb_sel_i);
                `SMC_IDX_DEV_CFG1: begin
                    cfg1_q <= wmerge(cfg1_q, wb_dat_i, wb_sel_i);
                end
                `SMC_IDX_DEV_CFG2: begin
                    cfg2_q <= wmerge(cfg2_q, wb_dat_i, wb_sel_i);
                end
                `SMC_IDX_CMD1: cmd1_q <= wmerge(cmd1_q, wb_dat_i, wb_sel_i);
                `SMC_IDX_CMD2: cmd2_q <= cmd2_new;
                `SMC_IDX_DATA1: begin
                    tx_q[15:0] <= wmerge(tx_q[15:0], wb_dat_i, wb_sel_i);
                end
                `SMC_IDX_DATA2: begin
                    tx_q[31:16] <= wmerge(tx_q[31:16], wb_dat_i, wb_sel_i);
                end
                default: tx_q <= tx_q; // unmapped writes ignored
            endcase
        end
    end

    // character and frame sequencer; this port always masters
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            csel_q <= 2'd0;
            frame_act_q <= 1'b0;
            flen_q <= 12'h000;
            cnt_q <= 12'h000;
            len_q <= 5'd0;
            bit_q <= 5'd0;
            dly_q <= 3'd0;
            sclk_q <= 1'b0;
            char_done_q <= 1'b0;
            frame_done_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            irq_q <= 1'b0;
            // status read clears; a same-cycle event wins below
            if (rd_go && idx == `SMC_IDX_STAT1) begin
                char_done_q <= 1'b0;
                frame_done_q <= 1'b0;
            end
            if (!en) begin
                // disable aborts the frame and parks the clock
                state_q <= ST_IDLE;
                frame_act_q <= 1'b0;
                cnt_q <= 12'h000;
                sclk_q <= cpol;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        sclk_q <= cpol;
                        if (start) begin
                            len_q <= cmd2_new[`SMC_CMD2_LEN_LO+4:
                                              `SMC_CMD2_LEN_LO];
                            bit_q <= 5'd0;
                            if (!frame_act_q) begin
                                // open a frame on the chosen select
                                csel_q <= cs_new;
                                // park clock at the new select's idle level
                                sclk_q <= cfg_new[`SMC_CFG_POL];
                                flen_q <= cmd1_q[11:0];
                                frame_act_q <= 1'b1;
                                dly_q <= {dly_new, 1'b0};
                                if (dly_new == 2'd0) begin
                                    state_q <= ST_LEAD;
                                end else begin
                                    state_q <= ST_DLY;
                                end
                            end else begin
                                state_q <= ST_LEAD;
                            end
                        end
                    end
                    ST_DLY: begin
                        // two half periods per delay clock
                        if (tick) begin
                            dly_q <= dly_q - 3'd1;
                            if (dly_q == 3'd1) begin
                                state_q <= ST_LEAD;
                            end
                        end
                    end
                    ST_LEAD: begin
                        if (tick) begin
                            sclk_q <= ~cpol;
                            state_q <= ST_TRAIL;
                        end
                    end
                    ST_TRAIL: begin
                        if (tick) begin
                            sclk_q <= cpol;
                            if (last_bit) begin
                                state_q <= ST_IDLE;
                            end else begin
                                bit_q <= bit_q + 5'd1;
                                state_q <= ST_LEAD;
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
                // character end: flags, interrupt, frame count
                if (char_end) begin
                    char_done_q <= 1'b1;
                    irq_q <= cmd1_q[`SMC_CMD1_IRQEN];
                    if (cnt_q == flen_q) begin
                        // select released after the last character, or earlier by disable
                        frame_act_q <= 1'b0;
                        cnt_q <= 12'h000;
                        frame_done_q <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 12'h001;
                    end
                end
            end
        end
    end

    // select levels: only the frame's select active, per-select level
    always @* begin : sel_next
        integer i;
        reg [7:0] c;
        i = 0;
        c = 8'h00;
        ss_d = 4'hF;
        for (i = 0; i < 4; i = i + 1) begin
            c = cfg_of(cfg1_q, cfg2_q, i[1:0]);
            ss_d[i] = c[`SMC_CFG_CSHI] ~^
                      (frame_act_q && csel_q == i[1:0]);
        end
    end

    // select pins come from flops
    always @(posedge clk_i) begin
        if (rst_i) begin
            ss_q <= 4'hF;
        end else begin
            ss_q <= ss_d;
        end
    end
endmodule

// ==== hdl/smc_defs.vh ====
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH

// register word indices; byte address is four times the index
`define SMC_IDX_CLK_DIV 14'h3000
`define SMC_IDX_CLK_CTL 14'h3001
`define SMC_IDX_DEV_CFG1 14'h3002
`define SMC_IDX_DEV_CFG2 14'h3003
`define SMC_IDX_CMD1 14'h3004
`define SMC_IDX_CMD2 14'h3005
`define SMC_IDX_STAT1 14'h3006
`define SMC_IDX_STAT2 14'h3007
`define SMC_IDX_DATA1 14'h3008
`define SMC_IDX_DATA2 14'h3009

// clock_control fields
`define SMC_CTL_EN 15
`define SMC_CTL_LOOP 0

// per chip-select config byte fields, stride in bits
`define SMC_CFG_POL 0
`define SMC_CFG_PHA 1
`define SMC_CFG_CSHI 2
`define SMC_CFG_DLY_LO 3
`define SMC_CFG_STRIDE 8

// command fields
`define SMC_CMD1_IRQEN 15
`define SMC_CMD2_START 0
`define SMC_CMD2_LEN_LO 2
`define SMC_CMD2_CS_LO 12

// status_one fields
`define SMC_ST_BUSY 0
`define SMC_ST_CHAR 1
`define SMC_ST_FRAME 2
`define SMC_ST_ACT 3

// reset values
`define SMC_RST_DIV 16'h0003
`define SMC_RST_REG 16'h0000

`endif

// ==== hdl/smc_clkdiv.v ====
`timescale 1ns/1ns
// half-period tick generator for the serial clock
module smc_clkdiv #(
    parameter W = 16
) (
    input wire clk_i,
    input wire rst_i,
    input wire run_i,
    input wire [W-1:0] div_i,
    output wire tick_o
);
    reg [W-1:0] cnt_q; // cycles since the last tick

    // one tick every div_i+1 cycles while running
    assign tick_o = run_i & (cnt_q == div_i);

    // counter restarts whenever the engine goes idle
    always @(posedge clk_i) begin
        if (rst_i || !run_i || tick_o) begin
            cnt_q <= {W{1'b0}};
        end else begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// ==== hdl/smc_shift.v ====
`timescale 1ns/1ns
// full-duplex character shifter, msb first
module smc_shift (
    input wire clk_i,
    input wire rst_i,
    input wire load_i,
    input wire [4:0] len_i,
    input wire [31:0] din_i,
    input wire shift_i,
    input wire sample_i,
    input wire rx_bit_i,
    output wire tx_bit_o,
    output wire [31:0] rx_data_o
);
    reg [31:0] sh_q; // transmit bits, next bit at the top
    reg [31:0] rx_q; // received bits, newest in bit 0

    assign tx_bit_o = sh_q[31];
    assign rx_data_o = rx_q;

    // load aligns the character msb to bit 31
    always @(posedge clk_i) begin
        if (rst_i) begin
            sh_q <= 32'h00000000;
            rx_q <= 32'h00000000;
        end else if (load_i) begin
            sh_q <= din_i << (5'd31 - len_i);
            rx_q <= 32'h00000000;
        end else begin
            if (shift_i) begin
                sh_q <= {sh_q[30:0], 1'b0};
            end
            if (sample_i) begin
                rx_q <= {rx_q[30:0], rx_bit_i};
            end
        end
    end
endmodule

// ==== dv/smc_checker.sv ====
`timescale 1ns/1ns
// port-level checks on the serial master
module smc_checker (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [15:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire serial_clk_o,
    input wire serial_tx_o,
    input wire serial_rx_i,
    input wire [3:0] slave_select_out_o,
    input wire char_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // new request on this edge
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // word index outside the map
    wire unmapped = (wb_adr_i[15:2] < 14'h3000) | (wb_adr_i[15:2] > 14'h3009);
    property p_ack_req; req |=> wb_ack_o; endproperty
    a_ack_req: assert property (p_ack_req)
        else $error("request not acknowledged");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i & wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    property p_dat_hi; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
    a_dat_hi: assert property (p_dat_hi)
        else $error("upper read half not zero");
    property p_unmapped;
        req && !wb_we_i && unmapped |=> wb_dat_o == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rst_idle;
        $fell(rst_i) |-> slave_select_out_o == 4'hF && !wb_ack_o
            && !serial_clk_o && !char_irq_o;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("outputs not idle after reset");
    property p_cs_steady;
        $changed(serial_clk_o) |-> $stable(slave_select_out_o);
    endproperty
    a_cs_steady: assert property (p_cs_steady)
        else $error("select moved with clock edge");
    property p_irq_pulse; char_irq_o |=> !char_irq_o; endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt longer than one cycle");
    c_irq: cover property (char_irq_o);
    c_sel: cover property (slave_select_out_o == 4'hD);
    c_wr: cover property (wb_ack_o && wb_we_i);
endmodule
bind smc_spi_master smc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_clk_o(serial_clk_o),
    .serial_tx_o(serial_tx_o), .serial_rx_i(serial_rx_i),
    .slave_select_out_o(slave_select_out_o), .char_irq_o(char_irq_o));

// ==== dv/smc_slave_model.sv ====
`timescale 1ns/1ns
// behavioural serial slave, msb first, any of the four modes
module smc_slave_model #(
    parameter logic [31:0] WORD = 32'hC35A0F96
) (
    input wire sclk_i,
    input wire [3:0] ss_i,
    input wire mosi_i,
    input wire pol_i,
    input wire pha_i,
    output logic miso_o,
    output logic [31:0] rx_o
);
    logic [31:0] sr; // outgoing bits
    initial begin
        miso_o = 1'b0;
        rx_o = 32'h0;
        sr = 32'h0;
    end
    // load on select; released line shows the inverse of its last bit
    always @(ss_i) begin
        if (ss_i != 4'hF) begin
            sr = pha_i ? WORD : WORD << 1;
            miso_o = pha_i ? ~miso_o : WORD[31];
        end else begin
            miso_o = ~miso_o;
        end
    end
    // sample on one edge, launch on the other
    always @(sclk_i) begin
        if (ss_i != 4'hF) begin
            if ((sclk_i != pol_i) ^ pha_i) begin
                rx_o = {rx_o[30:0], mosi_i};
            end else begin
                miso_o = sr[31];
                sr = sr << 1;
            end
        end
    end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
`include "smc_defs.vh"
// register-level bench for the serial master
module tb_top;
    localparam logic [31:0] SLV = 32'hC35A0F96; // slave reply word
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pol_m = 1'b0, pha_m = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [31:0] dat_w = 32'h0, q;
    logic [3:0] sel = 4'h3; // only the low two lanes matter
    logic [3:0] ss_p = 4'hF, ss_seen = 4'hF, e4;
    logic lead_done = 1'b1, sclk_p = 1'b0;
    wire [31:0] dat_r, rx_m;
    wire ack, sclk, tx, miso, irq;
    wire [3:0] ss;
    int fail_count = 0, n_checks = 0, cyc_n = 0, t_edge = 0, t_lead = 0;
    int t_cs = 0, gap = 0, irq_n = 0, irq_base = 0;
    int lead [4];
    smc_spi_master DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .serial_clk_o(sclk), .serial_tx_o(tx), .serial_rx_i(miso),
        .slave_select_out_o(ss), .char_irq_o(irq));
    smc_slave_model #(.WORD(SLV)) u_slv (.sclk_i(sclk), .ss_i(ss),
        .mosi_i(tx), .pol_i(pol_m), .pha_i(pha_m), .miso_o(miso),
        .rx_o(rx_m));
    initial forever #2 clk_i = ~clk_i;
    // edge timing of serial clock and select, interrupt count
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (irq === 1'b1) irq_n <= irq_n + 1;
        if (sclk !== sclk_p) begin
            gap <= cyc_n - t_edge;
            t_edge <= cyc_n;
            if (!lead_done && sclk !== pol_m) begin
                t_lead <= cyc_n;
                lead_done <= 1'b1;
            end
        end
        if (ss !== ss_p && ss !== 4'hF) begin
            t_cs <= cyc_n;
            ss_seen <= ss;
            lead_done <= 1'b0;
        end
        sclk_p <= sclk;
        ss_p <= ss;
    end
    task give_verdict;
        if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task bus(input logic w, input logic [13:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat_w <= {16'h0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            give_verdict;
        end
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    // poll busy until the character is done
    task wait_idle;
        int n;
        n = 0;
        do begin
            bus(1'b0, `SMC_IDX_STAT1, 16'h0000);
            n++;
        end while (q[0] !== 1'b0 && n < 500);
        if (n >= 500) begin
            fail_count++;
            give_verdict;
        end
    endtask
    // wait for the character interrupt, then let outputs settle
    task wait_irq;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (irq !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            fail_count++;
            give_verdict;
        end
        repeat (4) @(posedge clk_i);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(0, `SMC_IDX_CLK_DIV, 0);
        check(q, {16'h0000, `SMC_RST_DIV});
        bus(0, 14'h300A, 0);
        check(q, 32'h0);
        bus(1, `SMC_IDX_CLK_DIV, 16'h0002);
        bus(0, `SMC_IDX_CLK_DIV, 0);
        check(q, 32'h2);
        // four-clock half period leaves room for the receive synchroniser
        bus(1, `SMC_IDX_CLK_DIV, 16'h0003);
        bus(1, `SMC_IDX_DEV_CFG2, 16'h0004);
        repeat (3) @(posedge clk_i);
        check(ss, 4'hB);
        // select m runs mode m with delay m
        bus(1, `SMC_IDX_DEV_CFG1, 16'h0A00);
        bus(1, `SMC_IDX_DEV_CFG2, 16'h1B11);
        bus(1, `SMC_IDX_CLK_CTL, 16'h8000);
        for (int m = 0; m < 4; m++) begin
            pol_m <= m[1];
            pha_m <= m[0];
            bus(1, `SMC_IDX_CMD1, {m[0], 15'h0000});
            bus(1, `SMC_IDX_DATA1, 16'h003C + m[15:0]);
            bus(1, `SMC_IDX_CMD2, {2'b00, m[1:0], 12'h01C});
            irq_base = irq_n;
            bus(1, `SMC_IDX_CMD2, {2'b00, m[1:0], 12'h01D});
            wait_idle;
            lead[m] = t_lead - t_cs;
            e4 = ~(4'h1 << m);
            check(ss_seen, e4);
            bus(0, `SMC_IDX_DATA1, 0);
            check(q & 32'hFF, {24'h0, SLV[31:24]});
            check(rx_m[7:0], 8'h3C + m[7:0]);
            check(irq_n - irq_base, m[0]);
            check(gap, 4);
            check(lead[m] - lead[0], 8 * m);
        end
        // two-character frame of 32-bit words through loopback
        bus(1, `SMC_IDX_CLK_CTL, 16'h8001);
        bus(1, `SMC_IDX_CMD1, 16'h8001);
        bus(1, `SMC_IDX_DATA1, 16'h1234);
        bus(1, `SMC_IDX_DATA2, 16'hABCD);
        bus(1, `SMC_IDX_CMD2, 16'h107D);
        wait_irq;
        check(ss, 4'hD);
        bus(0, `SMC_IDX_STAT2, 0);
        check(q, 32'h1);
        bus(0, `SMC_IDX_DATA1, 0);
        check(q, 32'h1234);
        bus(0, `SMC_IDX_DATA2, 0);
        check(q, 32'hABCD);
        bus(1, `SMC_IDX_CMD2, 16'h307D);
        wait_irq;
        bus(0, `SMC_IDX_STAT1, 0);
        check(q[2], 1'b1);
        bus(0, `SMC_IDX_STAT1, 0);
        check(q[2], 1'b0);
        check(ss, 4'hF);
        give_verdict;
    end
endmodule
